// ===== logic/msr_defs.vh
// bit positions, masks and reset values for the meter status event block
// assumes inclusion by the status top design file of the block only
`ifndef MSR_DEFS_VH
`define MSR_DEFS_VH
`define MSR_SE_OPC        3
`define MSR_SE_OPC_BIT    0
`define MSR_SE_QYE_BIT    2
`define MSR_SE_DDE_BIT    3
`define MSR_SE_EXE_BIT    4
`define MSR_SE_CME_BIT    5
`define MSR_SE_PON_BIT    7
`define MSR_SE_MASK       8'hBD
`define MSR_QD_VOLT_BIT   0
`define MSR_QD_TEMP_BIT   4
`define MSR_QD_OHM_BIT    9
`define MSR_QD_MASK       16'h0211
`define MSR_SB_QDS_BIT    3
`define MSR_SB_MAV_BIT    4
`define MSR_SB_SES_BIT    5
`define MSR_OVL_VOLT      2'h0
`define MSR_OVL_TEMP      2'h1
`define MSR_OVL_OHM       2'h2
`define MSR_ZERO8         8'h00
`define MSR_ZERO16        16'h0000
`endif

// ===== logic/msr_event_reg.v
// latched event register with enable mask and summary output
// assumes single-cycle set pulses and synchronous clear strobes
`timescale 1ns/100ps
module msr_event_reg #(
    parameter WIDTH = 8,
    parameter [WIDTH-1:0] VALID = {WIDTH{1'b1}}
) (
    // clock and reset
    input  wire             clk,
    input  wire             rstN,
    // events and clears
    input  wire [WIDTH-1:0] setPulse,
    input  wire             clearEvents,
    // enable mask control
    input  wire             maskWrite,
    input  wire [WIDTH-1:0] maskData,
    input  wire             maskPowerClear,
    // state
    output reg  [WIDTH-1:0] events,
    output reg  [WIDTH-1:0] mask,
    output wire             summary
);
    // a set arriving with a clear wins so no event is lost
    always @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            events <= {WIDTH{1'b0}};
        end else begin
            events <= ((clearEvents ? {WIDTH{1'b0}} : events)
                       | setPulse) & VALID;
        end
    end

    // no reset on the mask: it must survive a power cycle when kept
    always @(posedge clk) begin
        if (maskPowerClear) begin
            mask <= {WIDTH{1'b0}};
        end else if (maskWrite) begin
            mask <= maskData & VALID;
        end
    end

    assign summary = |(events & mask);
endmodule

// ===== logic/msr_mav_ctrl.v
// message-available tracking and acquisition hold
// assumes buffer status inputs from the output buffer logic
`timescale 1ns/100ps
module msr_mav_ctrl (
    // clock and reset
    input  wire clk,
    input  wire rstN,
    // measurement flow
    input  wire firstTrigger,
    input  wire readMode,
    input  wire initDone,
    input  wire fetchCmd,
    input  wire outBufEmpty,
    input  wire outBufFull,
    input  wire opcPending,
    // results
    output reg  mavFlag,
    output reg  acqHalt,
    output reg  memToBuffer
);
    reg armed;
    reg moveLag;

    always @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            mavFlag     <= 1'b0;
            armed       <= 1'b0;
            acqHalt     <= 1'b0;
            memToBuffer <= 1'b0;
            moveLag     <= 1'b0;
        end else begin
            moveLag     <= memToBuffer;
            // readings only move after fetch, once initiate is done
            memToBuffer <= fetchCmd & initDone;
            acqHalt     <= outBufFull & opcPending;
            if (readMode & firstTrigger & ~armed) begin
                mavFlag <= 1'b1;
                armed   <= 1'b1;
            end else if (~readMode & fetchCmd & initDone) begin
                mavFlag <= 1'b1;
            // buffer fills two edges after the move, so hold off the clear
            end else if (outBufEmpty & ~memToBuffer & ~moveLag) begin
                mavFlag <= 1'b0;
                armed   <= 1'b0;
            end
        end
    end
endmodule

// ===== logic/msr_status_top.v
// top of meter status event reporting: standard event, questionable data,
// message-available and status byte summary bits
// assumes event inputs are single-cycle pulses synchronous to mclk
`timescale 1ns/100ps
`include "msr_defs.vh"
module msr_status_top (
    // clock and reset
    input  wire        mclk,
    input  wire        arst_n,
    // stored power-on-clear setting
    input  wire        powerOnClearSet,
    // command strobes
    input  wire        clearStatusCmd,
    input  wire        stdQueryCmd,
    input  wire        quesQueryCmd,
    input  wire        opcExecuted,
    input  wire        stdMaskWrite,
    input  wire [7:0]  stdMaskData,
    input  wire        quesMaskWrite,
    input  wire [15:0] quesMaskData,
    // error sources
    input  wire        readEmptyBuf,
    input  wire        unreadQueryLine,
    input  wire        bothBufFull,
    input  wire        selfTestFail,
    input  wire        calFail,
    input  wire        execError,
    input  wire        cmdError,
    input  wire        overloadPulse,
    input  wire [1:0]  overloadKind,
    // measurement flow
    input  wire        firstTrigger,
    input  wire        readMode,
    input  wire        initDone,
    input  wire        fetchCmd,
    input  wire        outBufEmpty,
    input  wire        outBufFull,
    input  wire        opcPending,
    // register read back
    output reg  [7:0]  stdEventFlags,
    output reg  [15:0] quesDataFlags,
    output reg  [7:0]  stdEnableMask,
    output reg  [15:0] quesEnableMask,
    output reg  [7:0]  statusByte,
    // error queue and flow
    output reg         errQueuePush,
    output reg         acqHalt,
    output reg         memToBuffer
);
    reg        rstSync1;
    reg        rstSync2;
    reg        powerUp;
    reg        seenPowerUp;
    wire [7:0] stdEvents;
    wire [7:0] stdMask;
    wire       stdSummary;
    wire [15:0] quesEvents;
    wire [15:0] quesMask;
    wire       quesSummary;
    wire       mavFlag;
    wire       acqHaltInt;
    wire       memToBufferInt;
    wire       queryErr;
    wire       devErr;
    wire       stdClear;
    wire       quesClear;
    reg  [7:0] stdSet;
    reg  [15:0] quesSet;

    // reset released through two flops
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rstSync1 <= 1'b0;
            rstSync2 <= 1'b0;
        end else begin
            rstSync1 <= 1'b1;
            rstSync2 <= rstSync1;
        end
    end

    // one pulse after release marks power-on
    always @(posedge mclk or negedge rstSync2) begin
        if (!rstSync2) begin
            seenPowerUp <= 1'b0;
            powerUp     <= 1'b0;
        end else begin
            seenPowerUp <= 1'b1;
            powerUp     <= ~seenPowerUp;
        end
    end

    function [15:0] ovlBit;
        input [1:0] kind;
        begin
            case (kind)
                `MSR_OVL_VOLT: ovlBit = 16'h0001;
                `MSR_OVL_TEMP: ovlBit = 16'h0010;
                `MSR_OVL_OHM:  ovlBit = 16'h0200;
                default:       ovlBit = `MSR_ZERO16;
            endcase
        end
    endfunction

    assign queryErr  = readEmptyBuf | unreadQueryLine | bothBufFull;
    assign devErr    = selfTestFail | calFail | overloadPulse;
    assign stdClear  = clearStatusCmd | stdQueryCmd;
    assign quesClear = clearStatusCmd | quesQueryCmd;

    always @* begin
        stdSet = `MSR_ZERO8;
        stdSet[`MSR_SE_OPC_BIT] = opcExecuted;
        stdSet[`MSR_SE_QYE_BIT] = queryErr;
        stdSet[`MSR_SE_DDE_BIT] = devErr;
        stdSet[`MSR_SE_EXE_BIT] = execError;
        stdSet[`MSR_SE_CME_BIT] = cmdError;
        stdSet[`MSR_SE_PON_BIT] = powerUp;
        quesSet = overloadPulse ? ovlBit(overloadKind) : `MSR_ZERO16;
    end

    msr_event_reg #(
        .WIDTH (8),
        .VALID (`MSR_SE_MASK)
    ) uStd (
        .clk            (mclk),
        .rstN           (rstSync2),
        .setPulse       (stdSet),
        .clearEvents    (stdClear),
        .maskWrite      (stdMaskWrite),
        .maskData       (stdMaskData),
        .maskPowerClear (powerUp & powerOnClearSet),
        .events         (stdEvents),
        .mask           (stdMask),
        .summary        (stdSummary)
    );

    msr_event_reg #(
        .WIDTH (16),
        .VALID (`MSR_QD_MASK)
    ) uQues (
        .clk            (mclk),
        .rstN           (rstSync2),
        .setPulse       (quesSet),
        .clearEvents    (quesClear),
        .maskWrite      (quesMaskWrite),
        .maskData       (quesMaskData),
        .maskPowerClear (powerUp),
        .events         (quesEvents),
        .mask           (quesMask),
        .summary        (quesSummary)
    );

    msr_mav_ctrl uMav (
        .clk          (mclk),
        .rstN         (rstSync2),
        .firstTrigger (firstTrigger),
        .readMode     (readMode),
        .initDone     (initDone),
        .fetchCmd     (fetchCmd),
        .outBufEmpty  (outBufEmpty),
        .outBufFull   (outBufFull),
        .opcPending   (opcPending),
        .mavFlag      (mavFlag),
        .acqHalt      (acqHaltInt),
        .memToBuffer  (memToBufferInt)
    );

    // outputs registered one cycle behind internal state
    always @(posedge mclk or negedge rstSync2) begin
        if (!rstSync2) begin
            stdEventFlags  <= `MSR_ZERO8;
            quesDataFlags  <= `MSR_ZERO16;
            stdEnableMask  <= `MSR_ZERO8;
            quesEnableMask <= `MSR_ZERO16;
            statusByte     <= `MSR_ZERO8;
            errQueuePush   <= 1'b0;
            acqHalt        <= 1'b0;
            memToBuffer    <= 1'b0;
        end else begin
            stdEventFlags  <= stdEvents;
            quesDataFlags  <= quesEvents;
            stdEnableMask  <= stdMask;
            quesEnableMask <= quesMask;
            statusByte     <= `MSR_ZERO8;
            statusByte[`MSR_SB_QDS_BIT] <= quesSummary;
            statusByte[`MSR_SB_MAV_BIT] <= mavFlag;
            statusByte[`MSR_SB_SES_BIT] <= stdSummary;
            // overload alone never queues an error
            errQueuePush <= queryErr | execError | cmdError
                            | selfTestFail | calFail;
            acqHalt        <= acqHaltInt;
            memToBuffer    <= memToBufferInt;
        end
    end
endmodule

// ===== testbench/msr_outbuf_model.sv
// output buffer as seen by the remote controller
// assumes bulk load pulses from the top, trigger load and read pulses from the bench
`timescale 1ns/100ps
module msr_outbuf_model #(
    parameter DEPTH = 4
) (
    // clock
    input wire  mclk,
    // loads and reads
    input wire  trigLoad,
    input wire  bulkLoad,
    input wire  readOut,
    // levels
    output wire bufEmpty,
    output wire bufFull
);
    integer count = 0;
    // fetch moves a whole run at once, so it fills the buffer
    always @(posedge mclk) begin
        if (bulkLoad) begin
            count <= DEPTH;
        end else if (trigLoad && count < DEPTH) begin
            count <= count + 1;
        end else if (readOut && count > 0) begin
            count <= count - 1;
        end
    end
    assign bufEmpty = (count == 0);
    assign bufFull = (count == DEPTH);
endmodule

// ===== testbench/msr_status_checker.sv
// port relations of the status event top
// assumes binding to msr_status_top, one clock domain
`timescale 1ns/100ps
module msr_status_checker (
    // clock and reset
    input wire        mclk,
    input wire        arst_n,
    // sources
    input wire        stdQueryCmd,
    input wire        clearStatusCmd,
    input wire        readEmptyBuf,
    input wire        unreadQueryLine,
    input wire        bothBufFull,
    input wire        selfTestFail,
    input wire        calFail,
    input wire        execError,
    input wire        cmdError,
    input wire        overloadPulse,
    input wire [1:0]  overloadKind,
    input wire        outBufFull,
    input wire        opcPending,
    // observed
    input wire [7:0]  stdEventFlags,
    input wire [15:0] quesDataFlags,
    input wire [7:0]  statusByte,
    input wire        errQueuePush,
    input wire        acqHalt
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    wire anyErr = readEmptyBuf | unreadQueryLine | bothBufFull
                | selfTestFail | calFail | execError | cmdError;
    sequence sVoltOvl;
        stdEventFlags[3] && quesDataFlags[0];
    endsequence
    sequence sVoltHit;
        overloadPulse && overloadKind == 2'h0;
    endsequence
    chk_exec_sets: assert property (execError |-> ##2 stdEventFlags[4])
        else $error("exec error bit not set");
    chk_ovl_volt: assert property (sVoltHit |-> ##2 sVoltOvl)
        else $error("overload bits not set");
    chk_err_push: assert property (anyErr |=> errQueuePush)
        else $error("error queue push missing");
    chk_ovl_quiet: assert property (overloadPulse && !anyErr |=> !errQueuePush)
        else $error("overload pushed error");
    chk_bit_latch: assert property ($fell(stdEventFlags[4]) |->
        $past(stdQueryCmd, 2) || $past(clearStatusCmd, 2))
        else $error("event bit dropped without clear");
    chk_std_zero: assert property (!stdEventFlags[1] && !stdEventFlags[6])
        else $error("unused standard bit set");
    chk_ques_zero: assert property ((quesDataFlags & 16'hFDEE) == 16'h0000)
        else $error("unused questionable bit set");
    chk_sb_zero: assert property (statusByte[2:0] == 3'h0)
        else $error("unused status byte bit set");
    chk_acq_halt: assert property ((outBufFull && opcPending) [*3] |-> acqHalt)
        else $error("acquisition not halted");
endmodule

// ===== testbench/msr_status_top_tb.sv
// self-checking bench of the status event top
// assumes strobes one cycle wide, results two edges later
`timescale 1ns/100ps
`define CHK(a, b) begin checked = checked + 1; if ((a) !== (b)) begin \
    bad_count = bad_count + 1; \
    $display("mismatch t=%0t %h %h", $time, a, b); end end
module msr_status_top_tb;
    reg         mclk = 1'b0;
    reg         arst_n = 1'b0;
    reg         pwrClr = 1'b1;
    reg  [16:0] strobe = 17'h0_0000;
    reg  [1:0]  kind = 2'h0;
    reg  [15:0] mData = 16'h0000;
    reg         readMode = 1'b0;
    reg         initDone = 1'b0;
    reg         opcPend = 1'b0;
    integer     pushCnt = 0;
    integer     moveCnt = 0;
    integer     mark = 0;
    wire        bufEmpty, bufFull, push, halt, move;
    wire [7:0]  stdF, stdM, sb;
    wire [15:0] quesF, quesM;
    integer     bad_count = 0;
    integer     checked = 0;
    integer     cyc = 0;
    integer     i;
    msr_status_top msr_status_top_i (.mclk(mclk), .arst_n(arst_n),
        .powerOnClearSet(pwrClr), .clearStatusCmd(strobe[0]),
        .stdQueryCmd(strobe[1]), .quesQueryCmd(strobe[2]),
        .opcExecuted(strobe[3]), .stdMaskWrite(strobe[4]),
        .stdMaskData(mData[7:0]), .quesMaskWrite(strobe[5]),
        .quesMaskData(mData), .readEmptyBuf(strobe[6]),
        .unreadQueryLine(strobe[7]), .bothBufFull(strobe[8]),
        .selfTestFail(strobe[9]), .calFail(strobe[10]),
        .execError(strobe[11]), .cmdError(strobe[12]),
        .overloadPulse(strobe[13]), .overloadKind(kind),
        .firstTrigger(strobe[14]), .readMode(readMode),
        .initDone(initDone), .fetchCmd(strobe[15]),
        .outBufEmpty(bufEmpty), .outBufFull(bufFull),
        .opcPending(opcPend), .stdEventFlags(stdF),
        .quesDataFlags(quesF), .stdEnableMask(stdM),
        .quesEnableMask(quesM), .statusByte(sb),
        .errQueuePush(push), .acqHalt(halt), .memToBuffer(move));
    msr_outbuf_model msr_outbuf_model_i (.mclk(mclk),
        .trigLoad(strobe[14]), .bulkLoad(move), .readOut(strobe[16]),
        .bufEmpty(bufEmpty), .bufFull(bufFull));
    initial begin
        forever #12.5 mclk = ~mclk;
    end
    // pulses are too short to sample later, so keep them sticky
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (push) pushCnt <= pushCnt + 1;
        if (move) moveCnt <= moveCnt + 1;
        if (cyc == 5000) begin
            bad_count = bad_count + 1;
            wrap_up;
        end
    end
    task wrap_up;
        begin
            if (bad_count == 0 && checked > 0) $display("TB: PASS");
            else $display("TB: FAIL");
            $finish;
        end
    endtask
    task hit(input integer b);
        begin
            @(posedge mclk) strobe[b] <= 1'b1;
            @(posedge mclk) strobe[b] <= 1'b0;
            repeat (2) @(posedge mclk);
            #1;
        end
    endtask
    task rdStd(input [7:0] exp);
        begin
            `CHK(stdF, exp)
            hit(1);
            `CHK(stdF, 8'h00)
        end
    endtask
    task wrMask(input integer b, input [15:0] d);
        begin
            @(posedge mclk) mData <= d;
            hit(b);
        end
    endtask
    initial begin
        repeat (3) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (8) @(posedge mclk);
        #1;
        rdStd(8'h80);
        wrMask(4, 16'h0001);
        hit(3);
        `CHK({stdF, sb[5]}, 9'h003)
        wrMask(4, 16'h0000);
        `CHK({stdM, sb[5]}, 9'h000)
        hit(0);
        `CHK(stdF, 8'h00)
        for (i = 6; i < 13; i = i + 1) begin
            mark = pushCnt;
            hit(i);
            `CHK(pushCnt != mark, 1'b1)
            rdStd(i < 9 ? 8'h04 : i < 11 ? 8'h08 : i == 11 ? 8'h10 : 8'h20);
        end
        wrMask(5, 16'hFFFF);
        `CHK(quesM, 16'h0211)
        for (i = 0; i < 3; i = i + 1) begin
            @(posedge mclk) kind <= i[1:0];
            mark = pushCnt;
            hit(13);
            `CHK({pushCnt != mark, sb[3]}, 2'b01)
            `CHK(quesF, i == 0 ? 16'h0001 : i == 1 ? 16'h0010 : 16'h0200)
            rdStd(8'h08);
            hit(2);
            `CHK(quesF, 16'h0000)
        end
        hit(13);
        @(posedge mclk) kind <= 2'h0;
        hit(13);
        `CHK(quesF, 16'h0201)
        hit(0);
        `CHK({quesF, stdF}, 24'h00_0000)
        wrMask(4, 16'h0001);
        @(posedge mclk) arst_n <= 1'b0;
        repeat (3) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (8) @(posedge mclk);
        #1;
        `CHK({stdM, quesM}, 24'h00_0000)
        rdStd(8'h80);
        wrMask(4, 16'h0021);
        @(posedge mclk) pwrClr <= 1'b0;
        arst_n <= 1'b0;
        repeat (3) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (8) @(posedge mclk);
        #1;
        `CHK({stdM, quesM}, 24'h21_0000)
        rdStd(8'h80);
        @(posedge mclk) readMode <= 1'b1;
        hit(14);
        `CHK(sb[4], 1'b1)
        hit(16);
        `CHK(sb[4], 1'b0)
        @(posedge mclk) readMode <= 1'b0;
        hit(15);
        `CHK({moveCnt != 0, sb[4]}, 2'b00)
        @(posedge mclk) initDone <= 1'b1;
        opcPend <= 1'b1;
        hit(15);
        repeat (3) @(posedge mclk);
        #1;
        `CHK({moveCnt == 1, sb[4], halt}, 3'b111)
        for (i = 0; i < 4; i = i + 1) hit(16);
        repeat (3) @(posedge mclk);
        #1;
        `CHK({sb[4], halt}, 2'b00)
        wrap_up;
    end
endmodule
bind msr_status_top msr_status_checker msr_status_checker_i (
    .mclk(mclk), .arst_n(arst_n), .stdQueryCmd(stdQueryCmd),
    .clearStatusCmd(clearStatusCmd), .readEmptyBuf(readEmptyBuf),
    .unreadQueryLine(unreadQueryLine), .bothBufFull(bothBufFull),
    .selfTestFail(selfTestFail), .calFail(calFail),
    .execError(execError), .cmdError(cmdError),
    .overloadPulse(overloadPulse), .overloadKind(overloadKind),
    .outBufFull(outBufFull), .opcPending(opcPending),
    .stdEventFlags(stdEventFlags), .quesDataFlags(quesDataFlags),
    .statusByte(statusByte), .errQueuePush(errQueuePush),
    .acqHalt(acqHalt));
